// [core/dpas_core.sv]
// Data processing unit: operand selection, ALU, flag update and status word.
//
// Summary of operation
// - Act only when the condition check passes.
// - First operand register; select shifted register or immediate.
// - Arithmetic opcodes 0010 to 0111 as specified.
// - Logical opcodes as specified, op1 sometimes ignored.
// - Opcodes 1000-1011 only set flags; with destination 15 the flags bit restores status instead.
// - Logical flag update keeps overflow, sets zero/negative.
// - Logical carry is shifter carry.
// - Arithmetic overflow flag from signed overflow.
// - Arithmetic carry, zero, negative from ALU.
// - Immediate shift amount is five bits.
// - Immediate left shift zero passes source, old carry.
// - Immediate right shift zero means shift 32.
// - Sign fill shift; zero amount means 32.
// - Rotate amount zero is rotate through carry.
// - Register amount uses lowest byte only.
// - Register amount zero passes source, old carry.
// - Logical shifts by 32 and beyond as specified.
// - Sign fill and rotate beyond 31 as specified.
// - Bit 7 set with register shift is not ours.
// - Immediate is eight bits rotated by twice field.
// - Destination counter gets result; flags bit restores status.
// - Counter operand reads address plus 8 or 12.
`timescale 1ns/10ps
module dpas_core
   import dpas_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Instruction issue from the decoder
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr,
   input  wire logic [31:0] instr_addr,
   input  wire logic        cond_pass,
   // Register bank read values
   input  wire logic [31:0] first_operand_val,
   input  wire logic [31:0] shift_source_val,
   input  wire logic [31:0] shift_amount_val,
   // Results to the register bank and decoder
   output logic             rd_we,
   output logic [3:0]       rd_idx,
   output logic [31:0]      rd_data,
   output logic             pc_we,
   output logic [31:0]      pc_data,
   output logic             done,
   output logic             undef,
   output logic             busy,
   output logic [31:0]      current_status_word,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic [31:0]      reg_rdata
);

   logic [1:0]     rst_sync_r;
   wire            rst_n;
   dpas_state_type state_r;
   dpas_state_type state_nxt;
   logic [31:0]    instr_r;
   logic [31:0]    addr_r;
   logic           cond_r;
   logic [31:0]    op1_r;
   logic [31:0]    src_r;
   logic [31:0]    amt_r;
   logic [1:0]     refill_r;
   logic [31:0]    csw_r;
   logic [31:0]    csw_nxt;
   logic [31:0]    ssw_r;
   logic [31:0]    result_r;
   logic           skipped_r;
   logic           rd_we_r;
   logic [3:0]     rd_idx_r;
   logic [31:0]    rd_data_r;
   logic           pc_we_r;
   logic [31:0]    pc_data_r;
   logic           done_r;
   logic           undef_r;
   logic           busy_r;
   logic [31:0]    reg_rdata_r;

   // Reset is released through two flip-flops.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Instruction decode from the captured word; in_reg_sh decodes the incoming word.
   wire            accept    = (state_r == S_IDLE) && instr_valid;
   wire            imm_sel   = instr_r[IMM_SEL_BIT];
   wire            set_flags = instr_r[SET_FLAGS_BIT];
   wire            reg_shift = !imm_sel && instr_r[REG_SHIFT_BIT];
   wire            in_reg_sh = !instr[IMM_SEL_BIT] && instr[REG_SHIFT_BIT];
   wire            not_ours  = reg_shift && instr_r[MUL_MARK_BIT];
   wire dpas_op_type opc     = dpas_op_type'(instr_r[OPC_HI:OPC_LO]);
   wire [3:0]      rn        = instr_r[RN_HI:RN_LO];
   wire [3:0]      rd        = instr_r[RD_HI:RD_LO];
   wire [3:0]      rm        = instr_r[RM_HI:RM_LO];
   wire            is_test   = (instr_r[OPC_HI:OPC_HI-1] == 2'b10);
   wire            is_arith  = (opc inside {[OP_DIFF:OP_REV_DIFF_BORROW], OP_CMP_DIFF, OP_CMP_SUM});
   wire            old_c     = csw_r[FLAG_C];

   // The counter reads ahead by the prefetch depth, one word more with a register amount.
   wire [31:0] pc_val = addr_r + (reg_shift ? PC_OFS_REG : PC_OFS_IMM);
   wire [31:0] op1    = (rn == PC_IDX) ? pc_val : op1_r;
   wire [31:0] src    = (rm == PC_IDX) ? pc_val : src_r;

   // Immediate second operand: byte rotated right by twice the rotate field.
   wire [4:0]  imm_rot = {instr_r[ROT_HI:ROT_LO], 1'b0};
   wire [31:0] imm_val = ror32({24'h0, instr_r[IMM8_HI:0]}, imm_rot);
   wire        imm_c   = (imm_rot == 5'h00) ? old_c : imm_val[31];

   wire [31:0] sh_res;
   wire        sh_c;
   wire [7:0]  sh_amt = reg_shift ? amt_r[7:0] : {3'h0, instr_r[SAMT_HI:SAMT_LO]};

   dpas_shifter u_shifter (
      .src        (src),
      .amount     (sh_amt),
      .kind       (dpas_shift_type'(instr_r[STYPE_HI:STYPE_LO])),
      .reg_amount (reg_shift),
      .carry_in   (old_c),
      .result     (sh_res),
      .carry_out  (sh_c)
   );

   wire [31:0] op2   = imm_sel ? imm_val : sh_res;
   wire        op2_c = imm_sel ? imm_c : sh_c;

   logic [31:0] logic_res;
   logic [31:0] add_a;
   logic [31:0] add_b;
   logic        add_cin;
   wire  [32:0] sum = {1'b0, add_a} + {1'b0, add_b} + {32'h0, add_cin};

   always_comb begin
      add_a   = op1;
      add_b   = ~op2;
      add_cin   = 1'b1;
      logic_res = 32'h0;
      unique case (opc)
         OP_CONJ, OP_TEST_CONJ:   logic_res = op1 & op2;
         OP_XDISJ, OP_TEST_EQUIV: logic_res = op1 ^ op2;
         OP_INCL_DISJ:            logic_res = op1 | op2;
         OP_PASS_TWO:             logic_res = op2;
         OP_BIT_CLEAR:            logic_res = op1 & ~op2;
         OP_INVERT_TWO:           logic_res = ~op2;
         OP_DIFF, OP_CMP_DIFF: begin
         end
         OP_REV_DIFF: begin
            add_a = op2;
            add_b = ~op1;
         end
         OP_SUM, OP_CMP_SUM: begin
            add_b   = op2;
            add_cin = 1'b0;
         end
         OP_SUM_CARRY: begin
            add_b   = op2;
            add_cin = old_c;
         end
         OP_DIFF_BORROW: begin
            add_cin = old_c;
         end
         OP_REV_DIFF_BORROW: begin
            add_a   = op2;
            add_b   = ~op1;
            add_cin = old_c;
         end
      endcase
   end

   wire [31:0] alu_res = is_arith ? sum[31:0] : logic_res;
   wire       res_zero = (alu_res == 32'h0);
   wire       ovf      = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
   wire [3:0] flags_nxt = is_arith ?
                          {alu_res[31], res_zero, sum[32], ovf} :
                          {alu_res[31], res_zero, op2_c, csw_r[FLAG_V]};

   // Execute only in the execution cycle, with a passing condition.
   wire act       = (state_r == S_EXEC) && cond_r && !not_ours;
   wire writes_pc = act && !is_test && (rd == PC_IDX);
   wire writes_rd = act && !is_test && (rd != PC_IDX);
   wire restore   = act && set_flags && (rd == PC_IDX);

   // Hardware flag updates win over a software write in the same cycle.
   always_comb begin
      csw_nxt = csw_r;
      if (restore) begin
         csw_nxt = ssw_r;
      end else if (act && set_flags) begin
         csw_nxt[FLAG_N:FLAG_V] = flags_nxt;
      end else if (reg_we && (reg_addr == REG_CSW)) begin
         csw_nxt = reg_wdata;
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE:   if (instr_valid) state_nxt = in_reg_sh ? S_SHIFT : S_EXEC;
         S_SHIFT:  state_nxt = S_EXEC;
         S_EXEC:   state_nxt = writes_pc ? S_REFILL : S_IDLE;
         S_REFILL: if (refill_r == 2'h1) state_nxt = S_IDLE;
      endcase
   end

   // Operands are held for the whole instruction so the bank may move on.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_r <= 32'h0;
         addr_r  <= 32'h0;
         cond_r  <= 1'b0;
         op1_r   <= 32'h0;
         src_r   <= 32'h0;
         amt_r   <= 32'h0;
      end else if (accept) begin
         instr_r <= instr;
         addr_r  <= instr_addr;
         cond_r  <= cond_pass;
         op1_r   <= first_operand_val;
         src_r   <= shift_source_val;
         amt_r   <= shift_amount_val;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r  <= S_IDLE;
         refill_r <= 2'h0;
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         refill_r <= writes_pc ? REFILL_CYCLES : refill_r - 2'h1;
         busy_r   <= (state_nxt != S_IDLE);
         done_r   <= (state_r != S_IDLE) && (state_nxt == S_IDLE);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_we_r   <= 1'b0;
         rd_idx_r  <= 4'h0;
         rd_data_r <= 32'h0;
         pc_we_r   <= 1'b0;
         pc_data_r <= 32'h0;
         undef_r   <= 1'b0;
      end else begin
         rd_we_r   <= writes_rd;
         rd_idx_r  <= (state_r == S_EXEC) ? rd : rd_idx_r;
         rd_data_r <= (state_r == S_EXEC) ? alu_res : rd_data_r;
         pc_we_r   <= writes_pc;
         pc_data_r <= writes_pc ? alu_res : pc_data_r;
         undef_r   <= (state_r == S_EXEC) && not_ours;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         csw_r     <= CSW_RESET;
         ssw_r     <= SSW_RESET;
         result_r  <= 32'h0;
         skipped_r <= 1'b0;
      end else begin
         csw_r     <= csw_nxt;
         ssw_r     <= (reg_we && (reg_addr == REG_SSW)) ? reg_wdata : ssw_r;
         result_r  <= act ? alu_res : result_r;
         skipped_r <= (state_r == S_EXEC) ? !act : skipped_r;
      end
   end

   // Read data stand for one cycle only; unmapped addresses read zero.
   wire [31:0] rd_mux = (reg_addr == REG_CSW)    ? csw_r :
                        (reg_addr == REG_SSW)    ? ssw_r :
                        (reg_addr == REG_RESULT) ? result_r :
                        (reg_addr == REG_STATE)  ? {29'h0, undef_r, skipped_r, busy_r} :
                        32'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= 32'h0;
      end else begin
         reg_rdata_r <= reg_re ? rd_mux : 32'h0;
      end
   end

   assign rd_we               = rd_we_r;
   assign rd_idx              = rd_idx_r;
   assign rd_data             = rd_data_r;
   assign pc_we               = pc_we_r;
   assign pc_data             = pc_data_r;
   assign done                = done_r;
   assign undef               = undef_r;
   assign busy                = busy_r;
   assign current_status_word = csw_r;
   assign reg_rdata           = reg_rdata_r;

   // Checks.
   property p_cond_fail_quiet;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == S_EXEC && !cond_r) |=> (!rd_we && !pc_we && done && $stable(csw_r[31:28]));
   endproperty
   a_cond_fail_quiet: assert property (p_cond_fail_quiet)
      else $error("Failed condition still had an effect.");

   property p_test_no_write;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == S_EXEC && is_test) |=> !rd_we && !pc_we;
   endproperty
   a_test_no_write: assert property (p_test_no_write)
      else $error("Test opcode wrote a register.");

   property p_logic_v_kept;
      @(posedge core_clk) disable iff (!rst_n)
      (act && set_flags && !is_arith && rd != PC_IDX)
         |=> csw_r[FLAG_V] == $past(csw_r[FLAG_V]) && csw_r[FLAG_Z] == $past(res_zero);
   endproperty
   a_logic_v_kept: assert property (p_logic_v_kept)
      else $error("Logical flag update wrong.");

   property p_lsl0_carry;
      @(posedge core_clk) disable iff (!rst_n)
      (act && set_flags && !is_arith && rd != PC_IDX && !imm_sel && !reg_shift &&
       instr_r[SAMT_HI:STYPE_LO] == 7'h00) |=> $stable(csw_r[FLAG_C]);
   endproperty
   a_lsl0_carry: assert property (p_lsl0_carry)
      else $error("Zero left shift changed carry.");

   property p_arith_flags;
      @(posedge core_clk) disable iff (!rst_n)
      (act && set_flags && is_arith && rd != PC_IDX)
         |=> csw_r[FLAG_N] == $past(sum[31]) && csw_r[FLAG_C] == $past(sum[32]);
   endproperty
   a_arith_flags: assert property (p_arith_flags)
      else $error("Arithmetic flags wrong.");

   property p_lsr32;
      @(posedge core_clk) disable iff (!rst_n)
      (!imm_sel && !reg_shift && instr_r[SAMT_HI:STYPE_LO] == 7'h01)
         |-> sh_res == 32'h0 && sh_c == src[31];
   endproperty
   a_lsr32: assert property (p_lsr32)
      else $error("Encoded right shift by 32 wrong.");

   property p_restore;
      @(posedge core_clk) disable iff (!rst_n)
      (restore && !is_test) |=> pc_we && csw_r == $past(ssw_r) ##1 !pc_we;
   endproperty
   a_restore: assert property (p_restore)
      else $error("Status word not restored with counter write.");

   property p_pc_offset;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == S_EXEC && rn == PC_IDX) |-> op1 == addr_r + (reg_shift ? 32'hc : 32'h8);
   endproperty
   a_pc_offset: assert property (p_pc_offset)
      else $error("Counter operand offset wrong.");

   property p_not_ours;
      @(posedge core_clk) disable iff (!rst_n)
      (accept && !instr[IMM_SEL_BIT] && instr[REG_SHIFT_BIT] && instr[MUL_MARK_BIT])
         |-> ##3 (undef && done && !rd_we && !pc_we);
   endproperty
   a_not_ours: assert property (p_not_ours)
      else $error("Register shift with bit 7 set was executed.");

endmodule

// [core/dpas_pkg.sv]
// Shared constants, types and helpers of the data processing ALU and shifter.
package dpas_pkg;

   // Instruction field positions.
   localparam int IMM_SEL_BIT   = 25;
   localparam int OPC_HI        = 24;
   localparam int OPC_LO        = 21;
   localparam int SET_FLAGS_BIT = 20;
   localparam int RN_HI         = 19;
   localparam int RN_LO         = 16;
   localparam int RD_HI         = 15;
   localparam int RD_LO         = 12;
   localparam int ROT_HI        = 11;
   localparam int ROT_LO        = 8;
   localparam int SAMT_HI       = 11;
   localparam int SAMT_LO       = 7;
   localparam int MUL_MARK_BIT  = 7;
   localparam int STYPE_HI      = 6;
   localparam int STYPE_LO      = 5;
   localparam int REG_SHIFT_BIT = 4;
   localparam int RM_HI         = 3;
   localparam int RM_LO         = 0;
   localparam int IMM8_HI       = 7;

   // Status word flag positions.
   localparam int FLAG_N = 31;
   localparam int FLAG_Z = 30;
   localparam int FLAG_C = 29;
   localparam int FLAG_V = 28;

   localparam logic [3:0]  PC_IDX        = 4'hf;
   localparam logic [31:0] PC_OFS_IMM    = 32'h0000_0008;
   localparam logic [31:0] PC_OFS_REG    = 32'h0000_000c;
   localparam logic [7:0]  SHIFT_FULL    = 8'h20;
   localparam logic [1:0]  REFILL_CYCLES = 2'h2;
   localparam logic [31:0] CSW_RESET     = 32'h0000_00d3;
   localparam logic [31:0] SSW_RESET     = 32'h0000_0000;

   // Register port map.
   localparam logic [7:0] REG_CSW    = 8'h00;
   localparam logic [7:0] REG_SSW    = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_STATE  = 8'h0c;

   typedef enum logic [3:0] {
      OP_CONJ            = 4'h0, OP_XDISJ           = 4'h1,
      OP_DIFF            = 4'h2, OP_REV_DIFF        = 4'h3,
      OP_SUM             = 4'h4, OP_SUM_CARRY       = 4'h5,
      OP_DIFF_BORROW     = 4'h6, OP_REV_DIFF_BORROW = 4'h7,
      OP_TEST_CONJ       = 4'h8, OP_TEST_EQUIV      = 4'h9,
      OP_CMP_DIFF        = 4'ha, OP_CMP_SUM         = 4'hb,
      OP_INCL_DISJ       = 4'hc, OP_PASS_TWO        = 4'hd,
      OP_BIT_CLEAR       = 4'he, OP_INVERT_TWO      = 4'hf
   } dpas_op_type;

   typedef enum logic [1:0] {
      SH_LOGICAL_LEFT    = 2'h0,
      SH_LOGICAL_RIGHT   = 2'h1,
      SH_SIGN_FILL_RIGHT = 2'h2,
      SH_ROTATE_RIGHT    = 2'h3
   } dpas_shift_type;

   typedef enum logic [1:0] {
      S_IDLE   = 2'h0,
      S_SHIFT  = 2'h1,
      S_EXEC   = 2'h2,
      S_REFILL = 2'h3
   } dpas_state_type;

   function automatic logic [31:0] ror32(input logic [31:0] v, input logic [4:0] n);
      logic [63:0] t;
      t = {v, v} >> n;
      return t[31:0];
   endfunction

endpackage

// [core/dpas_shifter.sv]
// Barrel shifter for the second operand, immediate and register amounts.
`timescale 1ns/10ps
module dpas_shifter
   import dpas_pkg::*;
(
   // Operand and control
   input  wire logic [31:0]   src,
   input  wire logic [7:0]    amount,
   input  wire dpas_shift_type kind,
   input  wire logic          reg_amount,
   input  wire logic          carry_in,
   // Result
   output logic [31:0]        result,
   output logic               carry_out
);

   wire               imm_zero;
   wire               ext_rot;
   wire        [7:0]  eff;
   wire        [5:0]  asr_amt;
   wire        [32:0] lsl_w;
   wire        [32:0] lsr_w;
   wire signed [32:0] asr_w;
   wire        [31:0] ror_w;

   // A zero immediate amount stands for a full 32-bit shift on the two right shifts; on the rotate it means rotate through carry.
   assign imm_zero = !reg_amount && (amount[4:0] == 5'h00);
   assign ext_rot  = imm_zero && (kind == SH_ROTATE_RIGHT);
   assign eff      = reg_amount ? amount :
                     imm_zero ? ((kind == SH_LOGICAL_LEFT) ? 8'h00 : SHIFT_FULL) :
                     {3'h0, amount[4:0]};
   assign asr_amt  = (eff > SHIFT_FULL) ? SHIFT_FULL[5:0] : eff[5:0];
   // The spare 33rd bit catches the last bit shifted out, which is the carry.
   assign lsl_w    = {1'b0, src} << eff;
   assign lsr_w    = {src, 1'b0} >> eff;
   assign asr_w    = $signed({src, 1'b0}) >>> asr_amt;
   assign ror_w    = ror32(src, eff[4:0]);

   always_comb begin
      result    = src;
      carry_out = carry_in;
      if (ext_rot) begin
         result    = {carry_in, src[31:1]};
         carry_out = src[0];
      end else if (eff != 8'h00) begin
         unique case (kind)
            SH_LOGICAL_LEFT: begin
               result    = lsl_w[31:0];
               carry_out = lsl_w[32];
            end
            SH_LOGICAL_RIGHT: begin
               result    = lsr_w[32:1];
               carry_out = lsr_w[0];
            end
            SH_SIGN_FILL_RIGHT: begin
               result    = asr_w[32:1];
               carry_out = asr_w[0];
            end
            SH_ROTATE_RIGHT: begin
               result    = ror_w;
               carry_out = ror_w[31];
            end
         endcase
      end
      // Amount zero leaves the defaults: source unchanged, old carry.
   end

endmodule

// [verification/dpas_bank_model.sv]
// Register bank model that feeds operand values and takes destination writes.
`timescale 1ns/10ps
module dpas_bank_model
   import dpas_pkg::*;
(
   // Clock and issued word
   input  wire logic        core_clk,
   input  wire logic [31:0] instr,
   // Writes from the unit
   input  wire logic        rd_we,
   input  wire logic [3:0]  rd_idx,
   input  wire logic [31:0] rd_data,
   // Operand values
   output logic [31:0]      first_operand_val,
   output logic [31:0]      shift_source_val,
   output logic [31:0]      shift_amount_val
);
   logic [31:0] regs [16];
   // Slot 15 holds junk, so a unit that reads it in place of the counter is caught.
   initial begin
      regs = '{32'h0, 32'hf0, 32'h8000_0001, 32'h4, 32'h104, 32'hffff_ffff, 32'h20, 32'h0,
               32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5a5a_a5a5};
   end
   assign first_operand_val = regs[instr[RN_HI:RN_LO]];
   assign shift_source_val  = regs[instr[RM_HI:RM_LO]];
   // The whole register is offered; only its low byte may count.
   assign shift_amount_val  = regs[instr[11:8]];
   always @(posedge core_clk) begin
      if (rd_we === 1'b1) begin
         regs[rd_idx] <= rd_data;
      end
   end
endmodule

// [verification/tb.sv]
// Self-checking bench of the data processing unit beside a register bank model.
`timescale 1ns/10ps
module tb
   import dpas_pkg::*;
;
   typedef struct packed {
      logic [31:0] ins;
      logic [31:0] res;
      logic [3:0]  fl;
      logic        wr;
   } dpas_row_type;
   dpas_row_type rows [18];
   logic        core_clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, cond_pass = 1'b1;
   logic        reg_we = 1'b0, reg_re = 1'b0;
   logic [31:0] instr = 32'h0, instr_addr = 32'h100, reg_wdata = 32'h0, v, f;
   logic [7:0]  reg_addr = 8'h0;
   logic [31:0] fo_val, ss_val, sa_val, rd_data, pc_data, current_status_word, reg_rdata;
   logic [3:0]  rd_idx;
   logic        rd_we, pc_we, done, undef, busy;
   int          failures = 0, comparisons = 0, wr_cnt, pc_cnt, ud_cnt, lat, base;

   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      wr_cnt += (rd_we === 1'b1);
      pc_cnt += (pc_we === 1'b1);
      ud_cnt += (undef === 1'b1);
   end

   dpas_core dpas_core_inst (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .instr(instr), .instr_addr(instr_addr), .cond_pass(cond_pass),
      .first_operand_val(fo_val), .shift_source_val(ss_val), .shift_amount_val(sa_val),
      .rd_we(rd_we), .rd_idx(rd_idx), .rd_data(rd_data), .pc_we(pc_we), .pc_data(pc_data),
      .done(done), .undef(undef), .busy(busy), .current_status_word(current_status_word),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata));
   dpas_bank_model dpas_bank_model_inst (.core_clk(core_clk), .instr(instr), .rd_we(rd_we),
      .rd_idx(rd_idx), .rd_data(rd_data), .first_operand_val(fo_val),
      .shift_source_val(ss_val), .shift_amount_val(sa_val));

   function automatic logic [31:0] enc(logic i, logic [3:0] op, logic [3:0] n, logic [3:0] d,
                                       logic [11:0] o2);
      return {4'he, 2'h0, i, op, 1'b1, n, d, o2};
   endfunction
   function automatic logic [11:0] sh(logic [4:0] a, logic [1:0] t, logic [3:0] m);
      return {a, t, 1'b0, m};
   endfunction
   function automatic logic [11:0] rs(logic [3:0] s, logic [1:0] t, logic [3:0] m);
      return {s, 1'b0, t, 1'b1, m};
   endfunction
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic issue(input logic [31:0] ins, input logic cp);
      wr_cnt = 0;
      pc_cnt = 0;
      ud_cnt = 0;
      @(posedge core_clk);
      instr <= ins;
      cond_pass <= cp;
      instr_valid <= 1'b1;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      #1;
      check(busy, 1'b1);
      lat = 1;
      while (done !== 1'b1 && lat < 20) begin
         @(posedge core_clk);
         #1;
         lat++;
      end
      if (lat >= 20) begin
         failures++;
         summarize();
      end
      // Let the strobes of this instruction be counted before the next issue clears them.
      @(posedge core_clk);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge core_clk);
      reg_we <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge core_clk);
      reg_re <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   initial begin
      rows[0]  = '{enc(1'b1, OP_PASS_TWO, 4'h0, 4'h8, 12'h102), 32'h8000_0000, 4'ha, 1'b1};
      rows[1]  = '{enc(1'b1, OP_SUM, 4'h5, 4'h9, 12'h001), 32'h0, 4'h6, 1'b1};
      rows[2]  = '{enc(1'b0, OP_SUM_CARRY, 4'h1, 4'h9, sh(0, 0, 1)), 32'h1e1, 4'h0, 1'b1};
      rows[3]  = '{enc(1'b0, OP_DIFF, 4'h1, 4'h9, sh(0, 0, 2)), 32'h8000_00ef, 4'h9, 1'b1};
      rows[4]  = '{enc(1'b0, OP_XDISJ, 4'h2, 4'h9, sh(0, 1, 5)), 32'h8000_0001, 4'hb, 1'b1};
      rows[5]  = '{enc(1'b1, OP_REV_DIFF, 4'h1, 4'h9, 12'h000), 32'hffff_ff10, 4'h8, 1'b1};
      rows[6]  = '{enc(1'b0, OP_DIFF_BORROW, 4'h1, 4'h9, sh(0, 0, 3)), 32'heb, 4'h2, 1'b1};
      rows[7]  = '{enc(1'b0, OP_REV_DIFF_BORROW, 4'h3, 4'h9, sh(0, 0, 1)), 32'hec, 4'h2, 1'b1};
      rows[8]  = '{enc(1'b0, OP_INCL_DISJ, 4'h1, 4'h9, sh(0, 2, 2)), 32'hffff_ffff, 4'ha, 1'b1};
      rows[9]  = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, sh(0, 3, 2)), 32'hc000_0000, 4'ha, 1'b1};
      rows[10] = '{enc(1'b0, OP_BIT_CLEAR, 4'h5, 4'h9, sh(4, 0, 1)), 32'hffff_f0ff, 4'h8, 1'b1};
      rows[11] = '{enc(1'b0, OP_INVERT_TWO, 4'h0, 4'h9, sh(1, 3, 3)), 32'hffff_fffd, 4'h8, 1'b1};
      rows[12] = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, rs(6, 0, 2)), 32'h0, 4'h6, 1'b1};
      rows[13] = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, rs(4, 1, 2)), 32'h0800_0000, 4'h0, 1'b1};
      rows[14] = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, rs(6, 3, 2)), 32'h8000_0001, 4'ha, 1'b1};
      rows[15] = '{enc(1'b0, OP_CMP_DIFF, 4'h1, 4'h0, sh(0, 0, 1)), 32'h0, 4'h6, 1'b0};
      rows[16] = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, sh(0, 0, 15)), 32'h108, 4'h2, 1'b1};
      rows[17] = '{enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, rs(0, 0, 15)), 32'h10c, 4'h2, 1'b1};
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check(current_status_word, CSW_RESET);
      for (int k = 0; k < 18; k++) begin
         issue(rows[k].ins, 1'b1);
         if (k == 0) base = lat;
         check(current_status_word[31:28], rows[k].fl);
         check(wr_cnt, rows[k].wr);
         check(rd_idx, rows[k].ins[15:12]);
         if (rows[k].wr) check(rd_data, rows[k].res);
         check(lat, base + (rows[k].ins[4] & ~rows[k].ins[25]));
      end
      check(base == 2 || base == 3, 1'b1);
      f = current_status_word;
      issue(enc(1'b1, OP_SUM, 4'h5, 4'h9, 12'h001), 1'b0);
      check(wr_cnt, 0);
      check(current_status_word, f);
      reg_rd(REG_STATE, v);
      check(v, 32'h0000_0002);
      issue(enc(1'b0, OP_PASS_TWO, 4'h0, 4'h9, rs(6, 0, 2) | 12'h080), 1'b1);
      check(ud_cnt, 1);
      check(wr_cnt, 0);
      reg_wr(REG_SSW, 32'hf000_0010);
      issue(enc(1'b1, OP_PASS_TWO, 4'h0, 4'hf, 12'h040), 1'b1);
      check(pc_cnt, 1);
      check(pc_data, 32'h40);
      check(current_status_word, 32'hf000_0010);
      check(lat, base + 2);
      issue(enc(1'b0, OP_TEST_CONJ, 4'h2, 4'h0, rs(6, 2, 2)), 1'b1);
      check(current_status_word[31:28], 4'hb);
      check(wr_cnt, 0);
      reg_rd(8'h40, v);
      check(v, 32'h0);
      reg_wr(REG_CSW, 32'h0000_001f);
      reg_rd(REG_CSW, v);
      check(v, 32'h0000_001f);
      issue(enc(1'b1, OP_SUM, 4'hf, 4'h9, 12'h004), 1'b1);
      check(rd_data, 32'h0000_010c);
      // A reset in mid-run must restore the status word and clear the counter data output.
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(current_status_word, CSW_RESET);
      check(pc_data, 32'h0);
      @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      issue(rows[1].ins, 1'b1);
      check(current_status_word[31:28], rows[1].fl);
      summarize();
   end
endmodule
